// >>> pei_led_select.sv
`timescale 1ns/1ps
module pei_led_select
  import pei_pkg::*;
(
  input wire logic [3:0] code,
  input wire pei_led_src_type src,
  input wire logic blink,
  output logic ledOn
);
  always_comb begin
    case (code)
      PEI_LED_ANY_ACT: ledOn = src.txActivity | src.rxActivity; // [RULE13]
      PEI_LED_TX_ACT: ledOn = src.txActivity; // [RULE13]
      PEI_LED_RX_ACT: ledOn = src.rxActivity; // [RULE13]
      PEI_LED_COLLISION: ledOn = src.collision; // [RULE13]
      PEI_LED_SPEED100: ledOn = src.speed100; // [RULE13]
      PEI_LED_SPEED10: ledOn = src.speed10; // [RULE13]
      PEI_LED_FULL_DUPLEX: ledOn = src.fullDuplex; // [RULE13]
      PEI_LED_LINK_BLINK: ledOn = src.linkGood & ~blink; // [RULE13]
      default: ledOn = 1'b0;
    endcase
  end
endmodule : pei_led_select

// >>> pei_mgmt_master.sv
`timescale 1ns/1ps
module pei_mgmt_master
  import pei_pkg::*;
(
  input wire logic clk,
  output pei_mgmt_req_type mgmtReq,
  input wire logic [15:0] mgmtRdData,
  input wire logic mgmtRdValid
);
  initial begin
    mgmtReq = '0;
  end
  // Released address and data never keep their last value
  task automatic idle_bus();
    mgmtReq.rdStrobe = 1'b0;
    mgmtReq.wrStrobe = 1'b0;
    mgmtReq.addr = ~mgmtReq.addr;
    mgmtReq.wrData = ~mgmtReq.wrData;
  endtask : idle_bus
  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    mgmtReq.wrStrobe = 1'b1;
    mgmtReq.addr = addr;
    mgmtReq.wrData = data;
    @(posedge clk);
    @(negedge clk);
    idle_bus();
    @(negedge clk);
  endtask : write_reg
  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data, output logic ok);
    mgmtReq.rdStrobe = 1'b1;
    mgmtReq.addr = addr;
    @(posedge clk);
    @(negedge clk);
    idle_bus();
    ok = mgmtRdValid;
    data = mgmtRdData;
    @(negedge clk);
  endtask : read_reg
endmodule : pei_mgmt_master

// >>> pei_phy_event_regs.sv
`timescale 1ns/1ps
module pei_phy_event_regs
  import pei_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire pei_mgmt_req_type mgmtReq,
  input wire pei_event_type events,
  input wire logic [15:0] diagIn,
  input wire pei_led_src_type ledSrc,
  output logic [15:0] mgmtRdData,
  output logic mgmtRdValid,
  output logic phyIrq,
  output logic [15:0] gainCtrl,
  output logic [15:0] crossoverCtrl,
  output logic led0,
  output logic led1
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] eventFlags;
  logic [7:0] eventEnables;
  logic linkGoodPrev;
  logic [15:0] diagReg;
  logic [15:0] ledCfg;
  logic [15:0] rdData;
  logic rdValid;
  logic [7:0] next_eventFlags;
  logic [7:0] next_eventEnables;
  logic [15:0] next_diagReg;
  logic [15:0] next_gainCtrl;
  logic [15:0] next_ledCfg;
  logic [15:0] next_crossoverCtrl;
  logic [15:0] next_rdData;
  logic next_rdValid;
  logic [7:0] eventHits;
  logic evtRead;
  logic evtWrite;
  logic blinkPhase;
  logic next_blinkPhase;
  logic next_led0;
  logic next_led1;
  logic next_linkGoodPrev;

  function automatic logic hit(input pei_mgmt_req_type r, input logic [4:0] a);
    hit = r.addr == a;
  endfunction : hit

  // Strobe qualified register match
  function automatic logic rd_hit(input pei_mgmt_req_type r, input logic [4:0] a);
    rd_hit = r.rdStrobe & hit(r, a);
  endfunction : rd_hit

  function automatic logic wr_hit(input pei_mgmt_req_type r, input logic [4:0] a);
    wr_hit = r.wrStrobe & hit(r, a);
  endfunction : wr_hit

  // Addresses that answer with register contents
  function automatic logic is_mapped(input logic [4:0] a);
    is_mapped = a == PEI_ADDR_EVENT || a == PEI_ADDR_DIAG || a == PEI_ADDR_GAIN || a == PEI_ADDR_LED ||
      a == PEI_ADDR_XOVER;
  endfunction : is_mapped

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  always_comb begin
    eventHits[7] = events.jabber; // [RULE5]
    eventHits[6] = events.receiveError; // [RULE6]
    eventHits[5] = events.pageArrived; // [RULE7]
    eventHits[4] = events.parallelDetectFault; // [RULE8]
    eventHits[3] = events.partnerAck; // [RULE9]
    eventHits[2] = linkGoodPrev & ~events.linkGood; // [RULE10]
    eventHits[1] = events.farFault; // [RULE11]
    eventHits[0] = events.negotiationDone; // [RULE12]
  end

  assign evtRead = rd_hit(mgmtReq, PEI_ADDR_EVENT);
  assign evtWrite = wr_hit(mgmtReq, PEI_ADDR_EVENT);

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  // A new event wins over the clear of a read
  always_comb begin
    next_eventFlags = eventFlags;
    if (evtRead) begin
      next_eventFlags = 8'h00; // [RULE2]
    end
    next_eventFlags = next_eventFlags | eventHits; // [RULE1] [RULE18]
    next_eventEnables = eventEnables;
    if (evtWrite) begin
      next_eventEnables = mgmtReq.wrData[PEI_ENABLE_LSB +: 8]; // [RULE3]
    end
    next_linkGoodPrev = events.linkGood;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eventFlags <= PEI_RST_EVENT[PEI_FLAG_LSB +: 8];
      eventEnables <= PEI_RST_EVENT[PEI_ENABLE_LSB +: 8];
      linkGoodPrev <= 1'b0;
    end else if (clkEn) begin
      eventFlags <= next_eventFlags;
      eventEnables <= next_eventEnables;
      linkGoodPrev <= next_linkGoodPrev;
    end
  end

  assign phyIrq = |(eventFlags & eventEnables); // [RULE3] [RULE18]

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Diagnostic word follows each finished negotiation
  always_comb begin
    next_diagReg = diagReg;
    if (events.negotiationDone) begin
      next_diagReg = diagIn; // [RULE15]
    end
    next_gainCtrl = gainCtrl;
    next_ledCfg = ledCfg;
    next_crossoverCtrl = crossoverCtrl;
    if (wr_hit(mgmtReq, PEI_ADDR_GAIN)) begin
      next_gainCtrl = mgmtReq.wrData; // [RULE16]
    end
    if (wr_hit(mgmtReq, PEI_ADDR_LED)) begin
      next_ledCfg = mgmtReq.wrData; // [RULE14]
    end
    if (wr_hit(mgmtReq, PEI_ADDR_XOVER)) begin
      next_crossoverCtrl = mgmtReq.wrData; // [RULE17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diagReg <= PEI_RST_DIAG;
      gainCtrl <= PEI_RST_GAIN;
      ledCfg <= PEI_RST_LED;
      crossoverCtrl <= PEI_RST_XOVER;
    end else if (clkEn) begin
      diagReg <= next_diagReg;
      gainCtrl <= next_gainCtrl;
      ledCfg <= next_ledCfg;
      crossoverCtrl <= next_crossoverCtrl;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    next_rdValid = mgmtReq.rdStrobe;
    next_rdData = rdData;
    if (mgmtReq.rdStrobe) begin
      case (mgmtReq.addr)
        PEI_ADDR_EVENT: next_rdData = {eventEnables, eventFlags}; // [RULE4]
        PEI_ADDR_DIAG: next_rdData = diagReg;
        PEI_ADDR_GAIN: next_rdData = gainCtrl;
        PEI_ADDR_LED: next_rdData = ledCfg;
        PEI_ADDR_XOVER: next_rdData = crossoverCtrl;
        default: next_rdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else if (clkEn) begin
      rdData <= next_rdData;
      rdValid <= next_rdValid;
    end
  end

  assign mgmtRdData = rdData;
  assign mgmtRdValid = rdValid;

  // ----------------------------------------
  // LEDs
  // ----------------------------------------
  // Blink phase runs only while there is activity
  always_comb begin
    next_blinkPhase = 1'b0;
    if (ledSrc.rxActivity || ledSrc.txActivity) begin
      next_blinkPhase = ~blinkPhase;
    end
  end

  pei_led_select u_led0 (
    .code(ledCfg[PEI_LED0_LSB +: 4]),
    .src(ledSrc),
    .blink(blinkPhase),
    .ledOn(next_led0)
  );
  pei_led_select u_led1 (
    .code(ledCfg[PEI_LED1_LSB +: 4]),
    .src(ledSrc),
    .blink(blinkPhase),
    .ledOn(next_led1)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blinkPhase <= 1'b0;
      led0 <= 1'b0;
      led1 <= 1'b0;
    end else if (clkEn) begin
      blinkPhase <= next_blinkPhase;
      led0 <= next_led0;
      led1 <= next_led1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Flag, freeze and diagnostic checks
  // ----------------------------------------

  jabber_sets_a: assert property (clkEn && events.jabber |=> eventFlags[7]) // [RULE5]
    else $error("jabber flag not set");
  rxerr_sets_a: assert property (clkEn && events.receiveError |=> eventFlags[6]) // [RULE6]
    else $error("receive error flag not set");
  page_sets_a: assert property (clkEn && events.pageArrived |=> eventFlags[5]) // [RULE7]
    else $error("page flag not set");
  pdf_sets_a: assert property (clkEn && events.parallelDetectFault |=> eventFlags[4]) // [RULE8]
    else $error("parallel fault flag not set");
  ack_sets_a: assert property (clkEn && events.partnerAck |=> eventFlags[3]) // [RULE9]
    else $error("ack flag not set");
  link_fail_a: assert property (clkEn && !evtRead && $rose(eventFlags[2]) |-> // [RULE10]
    $past(linkGoodPrev) && !$past(events.linkGood))
    else $error("link flag set without fall");
  fault_sets_a: assert property (clkEn && events.farFault |=> eventFlags[1]) // [RULE11]
    else $error("remote fault flag not set");
  done_sets_a: assert property (clkEn && events.negotiationDone |=> eventFlags[0]) // [RULE12]
    else $error("negotiation flag not set");
  read_clears_a: assert property (clkEn && evtRead && eventHits == 8'h00 |=> // [RULE2]
    eventFlags == 8'h00 && rdData[7:0] == $past(eventFlags))
    else $error("read did not clear or return flags");
  irq_follow_a: assert property (clkEn && !evtWrite && (eventHits & eventEnables) != 8'h00 |=> // [RULE18]
    phyIrq)
    else $error("enabled event did not raise irq");
  irq_drop_a: assert property (clkEn && evtRead && eventHits == 8'h00 |=> !phyIrq) // [RULE3]
    else $error("irq stayed after clearing read");
  flags_hold_a: assert property (clkEn && !evtRead && eventHits == 8'h00 |=> // [RULE1]
    eventFlags == $past(eventFlags))
    else $error("flags changed without event or read");
  link_steady_a: assert property (clkEn && !evtRead && !linkGoodPrev && !eventFlags[2] |=> // [RULE10]
    !eventFlags[2])
    else $error("link flag set while link stayed down");
  freeze_a: assert property (!clkEn |=> $stable(eventFlags) && $stable(ledCfg)) // [RULE1]
    else $error("state moved while disabled");
  diag_ro_a: assert property (clkEn && mgmtReq.wrStrobe && hit(mgmtReq, PEI_ADDR_DIAG) && // [RULE15]
    !events.negotiationDone |=> $stable(diagReg))
    else $error("diagnostic written");

  // ----------------------------------------
  // Register checks
  // ----------------------------------------

  enables_write_a: assert property (clkEn && evtWrite |=> // [RULE3]
    eventEnables == $past(mgmtReq.wrData[PEI_ENABLE_LSB +: 8]))
    else $error("enables not written");
  gain_write_a: assert property (clkEn && wr_hit(mgmtReq, PEI_ADDR_GAIN) |=> // [RULE16]
    gainCtrl == $past(mgmtReq.wrData))
    else $error("gain register not written");
  led_write_a: assert property (clkEn && wr_hit(mgmtReq, PEI_ADDR_LED) |=> // [RULE14]
    ledCfg == $past(mgmtReq.wrData))
    else $error("led register not written");
  xover_write_a: assert property (clkEn && wr_hit(mgmtReq, PEI_ADDR_XOVER) |=> // [RULE17]
    crossoverCtrl == $past(mgmtReq.wrData))
    else $error("crossover register not written");
  diag_capture_a: assert property (clkEn && events.negotiationDone |=> diagReg == $past(diagIn)) // [RULE15]
    else $error("diagnostic not captured");

  // ----------------------------------------
  // Read and LED checks
  // ----------------------------------------

  rd_valid_a: assert property (clkEn |=> mgmtRdValid == $past(mgmtReq.rdStrobe)) // [RULE4]
    else $error("read valid not one cycle after strobe");
  event_read_a: assert property (clkEn && evtRead |=> // [RULE4]
    mgmtRdData == {$past(eventEnables), $past(eventFlags)})
    else $error("event register read wrong");
  unmapped_read_a: assert property (clkEn && mgmtReq.rdStrobe && !is_mapped(mgmtReq.addr) |=> // [RULE4]
    mgmtRdData == 16'h0000)
    else $error("unmapped read not zero");
  led_tx_a: assert property (clkEn && ledCfg[PEI_LED0_LSB +: 4] == PEI_LED_TX_ACT |=> // [RULE13]
    led0 == $past(ledSrc.txActivity))
    else $error("led does not follow transmit activity");

  read_clear_c: cover property (evtRead && eventFlags != 8'h00);
  set_during_clear_c: cover property (evtRead && eventHits != 8'h00);
  irq_raised_c: cover property ($rose(phyIrq));
  led_write_c: cover property (mgmtReq.wrStrobe && hit(mgmtReq, PEI_ADDR_LED));
  link_drop_c: cover property (clkEn && eventHits[2]);
endmodule : pei_phy_event_regs

// >>> pei_pkg.sv
// Operation
// RULE1 - Low eight bits of event register are sticky event flags set by events.
// RULE2 - Reading the event register returns flags, then clears all eight flags.
// RULE3 - Upper eight bits enable matching flags onto the PHY interrupt line.
// RULE4 - Event register is readable over the management interface for polling.
// RULE5 - Flag bit 7 sets on a jabber condition.
// RULE6 - Flag bit 6 sets on a receive error.
// RULE7 - Flag bit 5 sets when a new page arrives from the partner.
// RULE8 - Flag bit 4 sets on a parallel detection fault.
// RULE9 - Flag bit 3 sets on an FLP burst with acknowledge set.
// RULE10 - Flag bit 2 sets only when link goes from good to failed.
// RULE11 - Flag bit 1 sets when the partner signals remote fault.
// RULE12 - Flag bit 0 sets when auto-negotiation completes successfully.
// RULE13 - LED source codes 0x1 to 0x8 select activity, tx, rx, collision, speeds, duplex, link.
// RULE14 - LED configuration register resets to 0x0010 and picks each LED's source.
// RULE15 - Diagnostic register is read-only, resets to 0x0000, shows last negotiation outcome.
// RULE16 - Transceiver control register resets to 0x4000, holds transmit gain.
// RULE17 - Crossover control register resets to 0x00C0, governs MDI/MDIX selection.
// RULE18 - Interrupt is OR of enabled flags; event during clearing read stays set.
package pei_pkg;
  localparam logic [4:0] PEI_ADDR_EVENT = 5'h11;
  localparam logic [4:0] PEI_ADDR_DIAG = 5'h12;
  localparam logic [4:0] PEI_ADDR_GAIN = 5'h13;
  localparam logic [4:0] PEI_ADDR_LED = 5'h17;
  localparam logic [4:0] PEI_ADDR_XOVER = 5'h18;
  localparam logic [15:0] PEI_RST_EVENT = 16'h0000;
  localparam logic [15:0] PEI_RST_DIAG = 16'h0000;
  localparam logic [15:0] PEI_RST_GAIN = 16'h4000;
  localparam logic [15:0] PEI_RST_LED = 16'h0010;
  localparam logic [15:0] PEI_RST_XOVER = 16'h00C0;
  localparam int PEI_FLAG_LSB = 0;
  localparam int PEI_ENABLE_LSB = 8;
  localparam int PEI_LED0_LSB = 0;
  localparam int PEI_LED1_LSB = 4;
  localparam logic [3:0] PEI_LED_ANY_ACT = 4'h1;
  localparam logic [3:0] PEI_LED_TX_ACT = 4'h2;
  localparam logic [3:0] PEI_LED_RX_ACT = 4'h3;
  localparam logic [3:0] PEI_LED_COLLISION = 4'h4;
  localparam logic [3:0] PEI_LED_SPEED100 = 4'h5;
  localparam logic [3:0] PEI_LED_SPEED10 = 4'h6;
  localparam logic [3:0] PEI_LED_FULL_DUPLEX = 4'h7;
  localparam logic [3:0] PEI_LED_LINK_BLINK = 4'h8;

  typedef struct packed {
    logic jabber;
    logic receiveError;
    logic pageArrived;
    logic parallelDetectFault;
    logic partnerAck;
    logic linkGood;
    logic farFault;
    logic negotiationDone;
  } pei_event_type;

  typedef struct packed {
    logic txActivity;
    logic rxActivity;
    logic collision;
    logic speed100;
    logic speed10;
    logic fullDuplex;
    logic linkGood;
  } pei_led_src_type;

  typedef struct packed {
    logic rdStrobe;
    logic wrStrobe;
    logic [4:0] addr;
    logic [15:0] wrData;
  } pei_mgmt_req_type;
endpackage : pei_pkg

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
  import pei_pkg::*;
;
  logic clk, rst_n, clkEn, mgmtRdValid, phyIrq, led0, led1, ok;
  logic [15:0] diagIn, mgmtRdData, gainCtrl, crossoverCtrl, rd;
  pei_mgmt_req_type mgmtReq;
  pei_event_type events;
  pei_led_src_type ledSrc;
  int badCount = 0;
  int cmpCount = 0;
  localparam logic [7:0] BASE = 8'h04;
  pei_phy_event_regs i_pei_phy_event_regs (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .mgmtReq(mgmtReq),
    .events(events), .diagIn(diagIn), .ledSrc(ledSrc), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
    .phyIrq(phyIrq), .gainCtrl(gainCtrl), .crossoverCtrl(crossoverCtrl), .led0(led0), .led1(led1));
  pei_mgmt_master i_pei_mgmt_master (.clk(clk), .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData),
    .mgmtRdValid(mgmtRdValid));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_check(input logic [4:0] addr, input logic [15:0] exp);
    i_pei_mgmt_master.read_reg(addr, rd, ok);
    check({15'h0000, ok}, 16'h0001);
    check(rd, exp);
    check({15'h0000, mgmtRdValid}, 16'h0000);
  endtask : rd_check
  // One-cycle event; link bit inverted means a link drop
  task automatic pulse(input int bitNo);
    events = pei_event_type'(BASE ^ (8'h01 << bitNo));
    @(negedge clk);
    events = pei_event_type'(BASE);
    @(negedge clk);
  endtask : pulse
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    check(gainCtrl, 16'h4000);
    check(crossoverCtrl, 16'h00C0);
    rd_check(PEI_ADDR_EVENT, 16'h0000);
    rd_check(PEI_ADDR_DIAG, 16'h0000);
    rd_check(PEI_ADDR_GAIN, 16'h4000);
    rd_check(PEI_ADDR_LED, 16'h0010);
    rd_check(PEI_ADDR_XOVER, 16'h00C0);
    rd_check(5'h00, 16'h0000);
    i_pei_mgmt_master.write_reg(PEI_ADDR_GAIN, 16'h2A5C);
    i_pei_mgmt_master.write_reg(PEI_ADDR_XOVER, 16'h0033);
    i_pei_mgmt_master.write_reg(PEI_ADDR_DIAG, 16'hFFFF);
    i_pei_mgmt_master.write_reg(PEI_ADDR_EVENT, 16'hFFFF);
    i_pei_mgmt_master.write_reg(5'h1F, 16'hFFFF);
    check(gainCtrl, 16'h2A5C);
    check(crossoverCtrl, 16'h0033);
    rd_check(PEI_ADDR_XOVER, 16'h0033);
    rd_check(PEI_ADDR_DIAG, 16'h0000);
    rd_check(PEI_ADDR_EVENT, 16'hFF00);
    rd_check(5'h1F, 16'h0000);
  endtask : test_regs
  task automatic test_events();
    i_pei_mgmt_master.write_reg(PEI_ADDR_EVENT, 16'hFF00);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      check({15'h0000, phyIrq}, 16'h0001);
      rd_check(PEI_ADDR_EVENT, 16'hFF00 | (16'h0001 << i));
      rd_check(PEI_ADDR_EVENT, 16'hFF00);
      check({15'h0000, phyIrq}, 16'h0000);
    end
    rd_check(PEI_ADDR_DIAG, 16'h5A3C);
  endtask : test_events
  task automatic test_mask();
    i_pei_mgmt_master.write_reg(PEI_ADDR_EVENT, 16'h0100);
    pulse(7);
    check({15'h0000, phyIrq}, 16'h0000);
    clkEn = 1'b0;
    pulse(5);
    clkEn = 1'b1;
    pulse(0);
    check({15'h0000, phyIrq}, 16'h0001);
    fork
      rd_check(PEI_ADDR_EVENT, 16'h0181);
      pulse(6);
    join
    rd_check(PEI_ADDR_EVENT, 16'h0140);
    check({15'h0000, phyIrq}, 16'h0000);
  endtask : test_mask
  task automatic test_led();
    logic [7:0] expOn;
    expOn = 8'h56;
    ledSrc = pei_led_src_type'(7'h55);
    for (int c = 0; c < 8; c++) begin
      i_pei_mgmt_master.write_reg(PEI_ADDR_LED, {8'h00, 4'h9, 4'(c)});
      repeat (3) @(negedge clk);
      check({15'h0000, led0}, {15'h0000, expOn[c]});
      check({15'h0000, led1}, 16'h0000);
    end
    ledSrc = pei_led_src_type'(7'h01);
    i_pei_mgmt_master.write_reg(PEI_ADDR_LED, 16'h0008);
    repeat (3) @(negedge clk);
    check({15'h0000, led0}, 16'h0001);
    // Link good with transmit activity must blink
    ledSrc = pei_led_src_type'(7'h41);
    i_pei_mgmt_master.write_reg(PEI_ADDR_LED, 16'h0028);
    repeat (3) @(negedge clk);
    check({15'h0000, led1}, 16'h0001);
    expOn[0] = led0;
    @(negedge clk);
    check({15'h0000, led0}, {15'h0000, ~expOn[0]});
  endtask : test_led
  task automatic test_reset();
    i_pei_mgmt_master.write_reg(PEI_ADDR_GAIN, 16'h1234);
    i_pei_mgmt_master.write_reg(PEI_ADDR_EVENT, 16'hFF00);
    pulse(3);
    check({15'h0000, phyIrq}, 16'h0001);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check(gainCtrl, 16'h4000);
    check(crossoverCtrl, 16'h00C0);
    check({13'h0000, led0, phyIrq, mgmtRdValid}, 16'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    rd_check(PEI_ADDR_EVENT, 16'h0000);
    rd_check(PEI_ADDR_LED, 16'h0010);
    rd_check(PEI_ADDR_GAIN, 16'h4000);
  endtask : test_reset
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    events = pei_event_type'(BASE);
    diagIn = 16'h5A3C;
    ledSrc = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    test_regs();
    test_events();
    test_mask();
    test_led();
    test_reset();
    final_report();
  end
  initial begin
    #(3000 * 100);
    badCount++;
    $display("[ERR] %0t: watchdog expired", $time);
    final_report();
  end
endmodule : tb_top
